/* File: scoc_out_gate.v */
`timescale 1ns/10ps
`include "scoc_regs.vh"
module scoc_out_gate (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       en_req_i,
  input  wire [1:0] fmt_i,
  output reg        p_en_o,
  output reg        n_en_o,
  output reg        run_o
);
  localparam integer SETTLE_I = (`SCOC_SETTLE_NS + `SCOC_CLK_NS - 1) / `SCOC_CLK_NS;
  localparam [6:0] SETTLE_CYC = SETTLE_I[6:0];
  localparam [1:0] ST_OFF    = 2'h0;
  localparam [1:0] ST_SETTLE = 2'h1;
  localparam [1:0] ST_RUN    = 2'h2;
  localparam [1:0] ST_STOP   = 2'h3;
  reg [1:0] state_r;
  reg [6:0] cnt_r;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_OFF;
      cnt_r   <= 7'h00;
      p_en_o  <= 1'b0;
      n_en_o  <= 1'b0;
      run_o   <= 1'b0;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (en_req_i) begin
            state_r <= ST_SETTLE;
            cnt_r   <= 7'h00;
            p_en_o  <= 1'b1;
            n_en_o  <= (fmt_i != `SCOC_FMT_CMOS);
          end
        end
        ST_SETTLE: begin
          n_en_o <= (fmt_i != `SCOC_FMT_CMOS);
          if (!en_req_i) begin
            state_r <= ST_STOP;
          end else if (cnt_r == SETTLE_CYC - 7'h01) begin
            state_r <= ST_RUN;
            run_o   <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 7'h01;
          end
        end
        ST_RUN: begin
          n_en_o <= (fmt_i != `SCOC_FMT_CMOS);
          if (!en_req_i) begin
            run_o   <= 1'b0;
            state_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          p_en_o  <= 1'b0;
          n_en_o  <= 1'b0;
          state_r <= ST_OFF;
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end
endmodule

/* File: scoc_regs.vh */
`ifndef SCOC_REGS_VH
`define SCOC_REGS_VH
// timing
`define SCOC_CLK_MHZ     40
`define SCOC_CLK_NS      25
`define SCOC_PWRUP_US    4000
`define SCOC_SETTLE_NS   2000
// serial frame: 8 command bits then 40 data bits, msb first
`define SCOC_CMD_BITS    8
`define SCOC_FRAME_BITS  48
`define SCOC_CMD_RD      7
// register indices
`define SCOC_IDX_SEC     7'h00
`define SCOC_IDX_PLLCTL  7'h02
`define SCOC_IDX_REFFMT  7'h03
`define SCOC_IDX_OUTFMT  7'h04
`define SCOC_IDX_PLLMODE 7'h05
`define SCOC_IDX_ODIV    7'h06
`define SCOC_IDX_FB1     7'h07
`define SCOC_IDX_FB2     7'h08
// pll_output_control fields
`define SCOC_P1_EN       0
`define SCOC_P1          1
`define SCOC_P2_EN       2
`define SCOC_P2          3
`define SCOC_RS1_EN      4
`define SCOC_RS1         5
`define SCOC_RS2_EN      6
`define SCOC_RS2         7
`define SCOC_OVR_LSB     8
`define SCOC_ON_LSB      9
`define SCOC_MR_EN       18
`define SCOC_MR          19
`define SCOC_PLLCTL_MSK  24'h07ffff
// output_format_xtal_trim fields
`define SCOC_GAIN_LSB    8
`define SCOC_CAP_LSB     12
`define SCOC_TRIM        15
`define SCOC_OUTFMT_MSK  16'hf7ff
// reference copy format sits in bits 31:30 of index 3
`define SCOC_REFFMT_LSB  30
// driver formats
`define SCOC_FMT_CMOS    2'b00
`define SCOC_FMT_LVDS    2'b01
`define SCOC_FMT_PECL    2'b10
`define SCOC_FMT_HCSL    2'b11
// otp image layout
`define SCOC_OTP_BITS    444
`define SCOC_OTP_SEC     0
`define SCOC_OTP_PLLCTL  8
`define SCOC_OTP_REFFMT  32
`define SCOC_OTP_OUTFMT  40
`define SCOC_OTP_PLLMODE 56
`define SCOC_OTP_ODIV    64
`define SCOC_OTP_FB1     96
`define SCOC_OTP_FB2     136
// otp default contents
`define SCOC_DEF_SEC     1'b0
`define SCOC_DEF_PLLCTL  24'h00000c
`define SCOC_DEF_REFFMT  2'h0
`define SCOC_DEF_OUTFMT  16'h0000
`define SCOC_DEF_PLLMODE 8'h00
`define SCOC_DEF_ODIV    32'h00000000
`define SCOC_DEF_FB      36'h000000000
`endif

/* File: scoc_spi_host.sv */
`timescale 1ns/10ps
module scoc_spi_host (
  input  wire        clk_i,
  input  wire        go_i,
  input  wire [47:0] frm_i,
  input  wire        sdo_i,
  output reg         sck_o,
  output reg         cs_n_o,
  output reg         sdi_o,
  output reg         done_o,
  output reg  [39:0] rdat_o
);
  integer i;
  initial begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
    done_o = 1'b0;
    rdat_o = 40'h0;
  end
  // mode 0 frame, 8 clk per serial bit, read bits taken at the last 40 falls
  always begin
    @(posedge clk_i);
    done_o <= 1'b0;
    if (go_i) begin
      cs_n_o <= 1'b0;
      for (i = 0; i < 48; i = i + 1) begin
        repeat (4) @(posedge clk_i);
        if (i > 8) rdat_o <= {rdat_o[38:0], sdo_i};
        sck_o <= 1'b0;
        sdi_o <= frm_i[47-i];
        repeat (4) @(posedge clk_i);
        sck_o <= 1'b1;
      end
      repeat (4) @(posedge clk_i);
      rdat_o <= {rdat_o[38:0], sdo_i};
      sck_o  <= 1'b0;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      sdi_o  <= ~sdi_o;
      repeat (6) @(posedge clk_i);
      done_o <= 1'b1;
    end
  end
endmodule

/* File: scoc_spi_slave.v */
`timescale 1ns/10ps
`include "scoc_regs.vh"
module scoc_spi_slave (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        enable_i,
  input  wire        sck_i,
  input  wire        cs_n_i,
  input  wire        sdi_i,
  input  wire [39:0] rd_data_i,
  output wire [6:0]  addr_o,
  output wire [39:0] wr_data_o,
  output reg         wr_stb_o,
  output reg         sdo_o,
  output reg         sdo_en_o
);
  reg  [2:0]  s1_r;
  reg  [2:0]  s2_r;
  reg         sck_d_r;
  reg  [5:0]  bit_cnt_r;
  reg  [7:0]  cmd_r;
  reg  [39:0] sh_r;
  reg  [39:0] tx_r;
  wire        rise;
  wire        fall;
  wire        active;
  wire        is_rd;

  assign rise      = s2_r[2] & ~sck_d_r;
  assign fall      = ~s2_r[2] & sck_d_r;
  assign active    = ~s2_r[1] & enable_i;
  assign is_rd     = cmd_r[`SCOC_CMD_RD];
  assign addr_o    = cmd_r[6:0];
  assign wr_data_o = sh_r;

  // pin synchronisers and frame engine
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_r      <= 3'h2;
      s2_r      <= 3'h2;
      sck_d_r   <= 1'b0;
      bit_cnt_r <= 6'h00;
      cmd_r     <= 8'h00;
      sh_r      <= 40'h0000000000;
      tx_r      <= 40'h0000000000;
      wr_stb_o  <= 1'b0;
      sdo_o     <= 1'b0;
      sdo_en_o  <= 1'b0;
    end else begin
      s1_r     <= {sck_i, cs_n_i, sdi_i};
      s2_r     <= s1_r;
      sck_d_r  <= s2_r[2];
      wr_stb_o <= 1'b0;
      if (!active) begin
        bit_cnt_r <= 6'h00;
        sdo_o     <= 1'b0;
        sdo_en_o  <= 1'b0;
      end else begin
        if (rise && bit_cnt_r != `SCOC_FRAME_BITS) begin
          bit_cnt_r <= bit_cnt_r + 6'h01;
          if (bit_cnt_r < `SCOC_CMD_BITS) begin
            cmd_r <= {cmd_r[6:0], s2_r[0]};
          end else begin
            sh_r <= {sh_r[38:0], s2_r[0]};
          end
          if (bit_cnt_r == `SCOC_FRAME_BITS - 1) begin
            wr_stb_o <= ~is_rd;
          end
        end
        if (fall && is_rd && bit_cnt_r == `SCOC_CMD_BITS) begin
          sdo_o    <= rd_data_i[39];
          tx_r     <= {rd_data_i[38:0], 1'b0};
          sdo_en_o <= 1'b1;
        end else if (fall && sdo_en_o) begin
          sdo_o <= tx_r[39];
          tx_r  <= {tx_r[38:0], 1'b0};
        end
      end
    end
  end
endmodule

/* File: scoc_top.v */
`timescale 1ns/10ps
`include "scoc_regs.vh"
// Function
// - after supply reset, pulse internal reset then load all registers from otp.
// - serial writes overwrite otp values unless the security bit is set.
// - 444 bits of otp hold the power-up default configuration.
// - each pll selects integer, fractional or rational mode independently.
// - fractional feedback divider is an 8-bit integer and 28-bit fraction.
// - two output dividers per pll, each ranging from 4 to 259.
// - each output divider also offers a divide-by-4.5 setting.
// - control bits 19:16 hold master reset, its enable, refcopy on and override.
// - control bits 7:0 hold value/enable pairs for source picks and plls.
// - with override low, output follows its pin and on bit reads the pin.
// - with override high, pin ignored and on bit switches the output.
// - five drivers, each with own enable pin and four formats.
// - format register holds four 2-bit modes and crystal trim, load, gain.
// - output formats power up from otp and software may change them.
// - format 00 cmos, 01 lvds, 10 lvpecl, 11 hcsl; cmos floats complement.
// - outputs one to four are active only while their feeding pll is powered; the reference copy is not gated.
// - pll1 follows power-down pin unless its enable bit is set.
// - newly enabled output holds static about 2 us, then toggles cleanly.
module scoc_top #(
  parameter [443:0] OTP_IMAGE = {272'h0, `SCOC_DEF_FB, 4'h0, `SCOC_DEF_FB, `SCOC_DEF_ODIV,
                                 `SCOC_DEF_PLLMODE, `SCOC_DEF_OUTFMT, 6'h00, `SCOC_DEF_REFFMT,
                                 `SCOC_DEF_PLLCTL, 7'h00, `SCOC_DEF_SEC},
  parameter integer PWRUP_CYC   = `SCOC_PWRUP_US * `SCOC_CLK_MHZ
) (
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        spi_sck_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_sdi_i,
  input  wire [3:0]  output_enable_pin_i,
  input  wire        refcopy_enable_pin_i,
  input  wire        pll1_powerdown_pin_n_i,
  output wire        spi_sdo_o,
  output wire        spi_sdo_en_o,
  output wire        cfg_ready_o,
  output wire        int_reset_o,
  output wire        pll1_up_o,
  output wire        pll2_up_o,
  output wire        pll1_source_pick_o,
  output wire        pll2_source_pick_o,
  output wire [1:0]  pll1_mode_o,
  output wire [1:0]  pll2_mode_o,
  output wire [7:0]  pll1_fb_int_o,
  output wire [27:0] pll1_fb_frac_o,
  output wire [7:0]  pll2_fb_int_o,
  output wire [27:0] pll2_fb_frac_o,
  output wire [31:0] out_div_code_o,
  output wire [3:0]  out_div_half_o,
  output wire [9:0]  driver_format_field_o,
  output wire        xtal_trim_o,
  output wire [2:0]  xtal_cap_o,
  output wire [2:0]  xtal_gain_o,
  output wire [4:0]  drv_p_en_o,
  output wire [4:0]  drv_n_en_o,
  output wire [4:0]  drv_run_o
);
  localparam        OTP_SEC     = OTP_IMAGE[`SCOC_OTP_SEC];
  localparam [23:0] OTP_PLLCTL  = OTP_IMAGE[`SCOC_OTP_PLLCTL +: 24] & `SCOC_PLLCTL_MSK;
  localparam [1:0]  OTP_REFFMT  = OTP_IMAGE[`SCOC_OTP_REFFMT +: 2];
  localparam [15:0] OTP_OUTFMT  = OTP_IMAGE[`SCOC_OTP_OUTFMT +: 16] & `SCOC_OUTFMT_MSK;
  localparam [7:0]  OTP_PLLMODE = OTP_IMAGE[`SCOC_OTP_PLLMODE +: 8];
  localparam [31:0] OTP_ODIV    = OTP_IMAGE[`SCOC_OTP_ODIV +: 32];
  localparam [35:0] OTP_FB1     = OTP_IMAGE[`SCOC_OTP_FB1 +: 36];
  localparam [35:0] OTP_FB2     = OTP_IMAGE[`SCOC_OTP_FB2 +: 36];
  localparam integer WAIT_LAST_I = PWRUP_CYC - 1;
  localparam [17:0] WAIT_LAST   = WAIT_LAST_I[17:0];

  reg  [1:0]  rst_pipe_r;
  wire        rst_n;
  reg  [5:0]  pin_s1_r;
  reg  [5:0]  pin_s2_r;
  wire [4:0]  en_pin;
  wire        pd_pin_n;
  reg  [17:0] wait_cnt_r;
  reg         cfg_ready_r;
  reg         int_reset_r;
  reg         sec_r;
  reg  [23:0] pllctl_r;
  reg  [1:0]  reffmt_r;
  reg  [15:0] outfmt_r;
  reg  [7:0]  pllmode_r;
  reg  [31:0] odiv_r;
  reg  [35:0] fb1_r;
  reg  [35:0] fb2_r;
  reg         pll1_up_r;
  reg         pll2_up_r;
  reg         src1_r;
  reg         src2_r;
  wire [6:0]  spi_addr;
  wire [39:0] spi_wdata;
  wire        spi_wstb;
  wire        wr_ok;
  wire        mr_hit;
  reg  [39:0] rd_data;
  wire [23:0] pllctl_rd;
  wire [4:0]  ovr;
  wire [4:0]  on_bit;
  wire [4:0]  on_rd;
  wire [4:0]  en_req;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_r <= 2'b00;
    end else begin
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_r[1];

  // enable and power-down pin synchronisers
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 6'h00;
      pin_s2_r <= 6'h00;
    end else begin
      pin_s1_r <= {pll1_powerdown_pin_n_i, refcopy_enable_pin_i, output_enable_pin_i};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign en_pin   = pin_s2_r[4:0];
  assign pd_pin_n = pin_s2_r[5];

  // internal reset pulse and power-up wait
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      int_reset_r <= 1'b1;
      wait_cnt_r  <= 18'h00000;
      cfg_ready_r <= 1'b0;
    end else begin
      int_reset_r <= mr_hit;
      if (int_reset_r) begin
        wait_cnt_r  <= 18'h00000;
        cfg_ready_r <= 1'b0;
      end else if (!cfg_ready_r) begin
        if (wait_cnt_r == WAIT_LAST) begin
          cfg_ready_r <= 1'b1;
        end else begin
          wait_cnt_r <= wait_cnt_r + 18'h00001;
        end
      end
    end
  end

  scoc_spi_slave u_spi (
    .clk_i     (clk_sys_i),
    .rst_n_i   (rst_n),
    .enable_i  (cfg_ready_r),
    .sck_i     (spi_sck_i),
    .cs_n_i    (spi_cs_n_i),
    .sdi_i     (spi_sdi_i),
    .rd_data_i (rd_data),
    .addr_o    (spi_addr),
    .wr_data_o (spi_wdata),
    .wr_stb_o  (spi_wstb),
    .sdo_o     (spi_sdo_o),
    .sdo_en_o  (spi_sdo_en_o)
  );

  assign wr_ok  = spi_wstb & ~sec_r;
  assign mr_hit = wr_ok & (spi_addr == `SCOC_IDX_PLLCTL) &
                  spi_wdata[`SCOC_MR] & spi_wdata[`SCOC_MR_EN];

  // configuration registers, reloaded from the otp image on every internal reset
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sec_r     <= OTP_SEC;
      pllctl_r  <= OTP_PLLCTL;
      reffmt_r  <= OTP_REFFMT;
      outfmt_r  <= OTP_OUTFMT;
      pllmode_r <= OTP_PLLMODE;
      odiv_r    <= OTP_ODIV;
      fb1_r     <= OTP_FB1;
      fb2_r     <= OTP_FB2;
    end else if (int_reset_r) begin
      sec_r     <= OTP_SEC;
      pllctl_r  <= OTP_PLLCTL;
      reffmt_r  <= OTP_REFFMT;
      outfmt_r  <= OTP_OUTFMT;
      pllmode_r <= OTP_PLLMODE;
      odiv_r    <= OTP_ODIV;
      fb1_r     <= OTP_FB1;
      fb2_r     <= OTP_FB2;
    end else if (wr_ok) begin
      case (spi_addr)
        `SCOC_IDX_PLLCTL:  pllctl_r  <= spi_wdata[23:0] & `SCOC_PLLCTL_MSK;
        `SCOC_IDX_REFFMT:  reffmt_r  <= spi_wdata[`SCOC_REFFMT_LSB +: 2];
        `SCOC_IDX_OUTFMT:  outfmt_r  <= spi_wdata[15:0] & `SCOC_OUTFMT_MSK;
        `SCOC_IDX_PLLMODE: pllmode_r <= spi_wdata[7:0];
        `SCOC_IDX_ODIV:    odiv_r    <= spi_wdata[31:0];
        `SCOC_IDX_FB1:     fb1_r     <= spi_wdata[35:0];
        `SCOC_IDX_FB2:     fb2_r     <= spi_wdata[35:0];
        default:           sec_r     <= sec_r;
      endcase
    end
  end

  // pll power and reference selection
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      pll1_up_r <= 1'b0;
      pll2_up_r <= 1'b0;
      src1_r    <= 1'b0;
      src2_r    <= 1'b0;
    end else begin
      pll1_up_r <= pllctl_r[`SCOC_P1_EN] ? pllctl_r[`SCOC_P1] : pd_pin_n;
      pll2_up_r <= pllctl_r[`SCOC_P2_EN] ? pllctl_r[`SCOC_P2] : 1'b1;
      src1_r    <= pllctl_r[`SCOC_RS1_EN] & pllctl_r[`SCOC_RS1];
      src2_r    <= pllctl_r[`SCOC_RS2_EN] & pllctl_r[`SCOC_RS2];
    end
  end

  // per driver: outputs one to four, then the reference copy at bits 17:16
  genvar k;
  generate
    for (k = 0; k < 5; k = k + 1) begin : g_drv
      wire       pll_ok;
      wire [1:0] fmt;
      assign ovr[k]    = pllctl_r[`SCOC_OVR_LSB + 2 * k];
      assign on_bit[k] = pllctl_r[`SCOC_ON_LSB + 2 * k];
      assign on_rd[k]  = ovr[k] ? on_bit[k] : en_pin[k];
      assign pll_ok    = (k < 2) ? pll1_up_r : ((k < 4) ? pll2_up_r : 1'b1);
      assign en_req[k] = (ovr[k] ? on_bit[k] : en_pin[k]) & pll_ok;
      assign fmt       = (k < 4) ? outfmt_r[2 * k +: 2] : reffmt_r;
      scoc_out_gate u_gate (
        .clk_i    (clk_sys_i),
        .rst_n_i  (rst_n),
        .en_req_i (en_req[k]),
        .fmt_i    (fmt),
        .p_en_o   (drv_p_en_o[k]),
        .n_en_o   (drv_n_en_o[k]),
        .run_o    (drv_run_o[k])
      );
    end
  endgenerate

  assign pllctl_rd = {pllctl_r[23:18], on_rd[4], pllctl_r[16], on_rd[3], pllctl_r[14],
                      on_rd[2], pllctl_r[12], on_rd[1], pllctl_r[10], on_rd[0],
                      pllctl_r[8:0]};

  // register read mux
  always @* begin
    rd_data = 40'h0000000000;
    case (spi_addr)
      `SCOC_IDX_SEC:     rd_data[0]     = sec_r;
      `SCOC_IDX_PLLCTL:  rd_data[23:0]  = pllctl_rd;
      `SCOC_IDX_REFFMT:  rd_data[`SCOC_REFFMT_LSB +: 2] = reffmt_r;
      `SCOC_IDX_OUTFMT:  rd_data[15:0]  = outfmt_r;
      `SCOC_IDX_PLLMODE: rd_data[7:0]   = pllmode_r;
      `SCOC_IDX_ODIV:    rd_data[31:0]  = odiv_r;
      `SCOC_IDX_FB1:     rd_data[35:0]  = fb1_r;
      `SCOC_IDX_FB2:     rd_data[35:0]  = fb2_r;
      default:           rd_data        = 40'h0000000000;
    endcase
  end

  assign cfg_ready_o           = cfg_ready_r;
  assign int_reset_o           = int_reset_r;
  assign pll1_up_o             = pll1_up_r;
  assign pll2_up_o             = pll2_up_r;
  assign pll1_source_pick_o    = src1_r;
  assign pll2_source_pick_o    = src2_r;
  assign pll1_mode_o           = pllmode_r[1:0];
  assign pll2_mode_o           = pllmode_r[3:2];
  assign out_div_half_o        = pllmode_r[7:4];
  assign pll1_fb_int_o         = fb1_r[35:28];
  assign pll1_fb_frac_o        = fb1_r[27:0];
  assign pll2_fb_int_o         = fb2_r[35:28];
  assign pll2_fb_frac_o        = fb2_r[27:0];
  assign out_div_code_o        = odiv_r;
  assign driver_format_field_o = {reffmt_r, outfmt_r[7:0]};
  assign xtal_trim_o           = outfmt_r[`SCOC_TRIM];
  assign xtal_cap_o            = outfmt_r[`SCOC_CAP_LSB +: 3];
  assign xtal_gain_o           = outfmt_r[`SCOC_GAIN_LSB +: 3];
endmodule

/* File: scoc_top_properties.sv */
`timescale 1ns/10ps
module scoc_top_properties #(
  parameter [443:0] OTP_IMAGE = 444'h0,
  parameter integer PWRUP_CYC = 160000
) (
  input wire       clk_sys_i,
  input wire       rst_n_i,
  input wire       spi_cs_n_i,
  input wire       spi_sdo_en_o,
  input wire       cfg_ready_o,
  input wire       int_reset_o,
  input wire       pll1_up_o,
  input wire       pll2_up_o,
  input wire [1:0] pll1_mode_o,
  input wire [9:0] driver_format_field_o,
  input wire [4:0] drv_p_en_o,
  input wire [4:0] drv_n_en_o,
  input wire [4:0] drv_run_o
);
  integer    wait_cnt;
  integer    settle_cnt;
  wire [4:0] fmt_nz;
  genvar k;
  for (k = 0; k < 5; k = k + 1) begin : g_nz
    assign fmt_nz[k] = |driver_format_field_o[2*k+1 -: 2];
  end
  default clocking cb_sys @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // cycles since reload, cycles output 1 driven
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_cnt   <= 0;
      settle_cnt <= 0;
    end else begin
      wait_cnt   <= int_reset_o ? 0 : wait_cnt + 1;
      settle_cnt <= drv_p_en_o[0] ? settle_cnt + 1 : 0;
    end
  end
  AST_READY_WAIT:
    assert property ($rose(cfg_ready_o) |-> wait_cnt >= PWRUP_CYC - 1 && wait_cnt <= PWRUP_CYC + 1)
    else $error("ready at wrong time");
  AST_RELOAD_LOCK:
    assert property (int_reset_o |=> !cfg_ready_o) else $error("ready during reload");
  AST_RELOAD_VALUES:
    assert property (int_reset_o |-> ##[1:2] (driver_format_field_o ==
      {OTP_IMAGE[33:32], OTP_IMAGE[47:40]} && pll1_mode_o == OTP_IMAGE[57:56]))
    else $error("reload values wrong");
  AST_CMOS_FLOATS:
    assert property ((drv_n_en_o & ~$past(fmt_nz) & ~$past(fmt_nz, 2)) == 5'h00)
    else $error("complement driven in cmos");
  AST_RUN_NEEDS_DRIVE:
    assert property ((drv_run_o & ~drv_p_en_o) == 5'h00) else $error("run while undriven");
  AST_SETTLE_TIME:
    assert property ($rose(drv_run_o[0]) |-> settle_cnt inside {[79:81]})
    else $error("settle time wrong");
  AST_STOP_ORDER:
    assert property ($fell(drv_run_o[0]) |=> !drv_p_en_o[0]) else $error("stop order wrong");
  AST_PLL1_FEEDS:
    assert property (!pll1_up_o [*3] |-> drv_p_en_o[1:0] == 2'b00)
    else $error("output on with pll1 down");
  AST_PLL2_FEEDS:
    assert property (!pll2_up_o [*3] |-> drv_p_en_o[3:2] == 2'b00)
    else $error("output on with pll2 down");
  AST_PORT_LOCKED:
    assert property (!cfg_ready_o |-> !spi_sdo_en_o) else $error("sdo driven while locked");
  AST_SDO_IDLE:
    assert property (spi_cs_n_i [*6] |-> !spi_sdo_en_o) else $error("sdo driven when idle");
  cover property ($rose(cfg_ready_o));
  cover property ($rose(drv_run_o[0]));
  cover property (cfg_ready_o && int_reset_o);
endmodule
bind scoc_top scoc_top_properties #(.OTP_IMAGE(OTP_IMAGE), .PWRUP_CYC(PWRUP_CYC)) u_props (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_sdo_en_o(spi_sdo_en_o), .cfg_ready_o(cfg_ready_o), .int_reset_o(int_reset_o),
  .pll1_up_o(pll1_up_o), .pll2_up_o(pll2_up_o), .pll1_mode_o(pll1_mode_o),
  .driver_format_field_o(driver_format_field_o), .drv_p_en_o(drv_p_en_o),
  .drv_n_en_o(drv_n_en_o), .drv_run_o(drv_run_o));

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  reg         clk_sys_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [3:0]  output_enable_pin_i = 4'h3;
  reg         refcopy_enable_pin_i = 1'b1;
  reg         pll1_powerdown_pin_n_i = 1'b1;
  reg         go = 1'b0;
  reg  [47:0] frm = 48'h0;
  reg         junk = 1'b0;
  wire        spi_sck_i, spi_cs_n_i, spi_sdi_i, spi_sdo_o, spi_sdo_en_o, done;
  wire        cfg_ready_o, int_reset_o, pll1_up_o, pll2_up_o, xtal_trim_o;
  wire        pll1_source_pick_o, pll2_source_pick_o;
  wire [1:0]  pll1_mode_o, pll2_mode_o;
  wire [7:0]  pll1_fb_int_o, pll2_fb_int_o;
  wire [27:0] pll1_fb_frac_o, pll2_fb_frac_o;
  wire [31:0] out_div_code_o;
  wire [3:0]  out_div_half_o;
  wire [9:0]  driver_format_field_o;
  wire [2:0]  xtal_cap_o, xtal_gain_o;
  wire [4:0]  drv_p_en_o, drv_n_en_o, drv_run_o;
  wire [39:0] rdat;
  integer     seed = 32'h4e67;
  integer     err_count = 0;
  integer     checked = 0;
  integer     i, n;
  reg  [39:0] v;
  reg  [39:0] rdq[$];
  reg  [7:0]  m8;
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) junk <= ~junk;
  scoc_top #(.PWRUP_CYC(20)) u_scoc_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .spi_sck_i(spi_sck_i), .spi_cs_n_i(spi_cs_n_i), .spi_sdi_i(spi_sdi_i),
    .output_enable_pin_i(output_enable_pin_i), .refcopy_enable_pin_i(refcopy_enable_pin_i),
    .pll1_powerdown_pin_n_i(pll1_powerdown_pin_n_i), .spi_sdo_o(spi_sdo_o),
    .spi_sdo_en_o(spi_sdo_en_o), .cfg_ready_o(cfg_ready_o), .int_reset_o(int_reset_o),
    .pll1_up_o(pll1_up_o), .pll2_up_o(pll2_up_o), .pll1_source_pick_o(pll1_source_pick_o),
    .pll2_source_pick_o(pll2_source_pick_o), .pll1_mode_o(pll1_mode_o),
    .pll2_mode_o(pll2_mode_o), .pll1_fb_int_o(pll1_fb_int_o),
    .pll1_fb_frac_o(pll1_fb_frac_o), .pll2_fb_int_o(pll2_fb_int_o),
    .pll2_fb_frac_o(pll2_fb_frac_o), .out_div_code_o(out_div_code_o),
    .out_div_half_o(out_div_half_o), .driver_format_field_o(driver_format_field_o),
    .xtal_trim_o(xtal_trim_o), .xtal_cap_o(xtal_cap_o), .xtal_gain_o(xtal_gain_o),
    .drv_p_en_o(drv_p_en_o), .drv_n_en_o(drv_n_en_o), .drv_run_o(drv_run_o));
  scoc_spi_host u_scoc_spi_host (.clk_i(clk_sys_i), .go_i(go), .frm_i(frm),
    .sdo_i(spi_sdo_en_o ? spi_sdo_o : junk), .sck_o(spi_sck_i), .cs_n_o(spi_cs_n_i),
    .sdi_o(spi_sdi_i), .done_o(done), .rdat_o(rdat));
  task chk(input [39:0] got, input [39:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task tick;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task xfer(input [7:0] cmd, input [39:0] d);
    begin
      @(posedge clk_sys_i);
      go  <= 1'b1;
      frm <= {cmd, d};
      @(posedge clk_sys_i);
      go <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 1000) begin
        @(posedge clk_sys_i);
        n = n + 1;
      end
      if (n >= 1000) err_count = err_count + 1;
    end
  endtask
  task wr(input [6:0] idx, input [39:0] d);
    xfer({1'b0, idx}, d);
  endtask
  task rd(input [6:0] idx, input [39:0] e);
    begin
      rdq.push_back(e);
      xfer({1'b1, idx}, 40'h0);
    end
  endtask
  task ready;
    begin
      n = 0;
      while (cfg_ready_o !== 1'b1 && n < 500) begin
        @(posedge clk_sys_i);
        n = n + 1;
      end
      chk(cfg_ready_o, 1'b1);
      tick;
    end
  endtask
  // read data against the oldest note
  always @(posedge clk_sys_i)
    if (done === 1'b1 && frm[47] && rdq.size() > 0) chk(rdat, rdq.pop_front());
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    ready;
    chk(driver_format_field_o, 10'h000);
    chk({pll2_up_o, drv_p_en_o, drv_n_en_o}, 11'h660);
    rd(7'h02, 40'h020a0c);
    pll1_powerdown_pin_n_i <= 1'b0;
    tick;
    chk({pll1_up_o, drv_p_en_o}, 6'h10);
    output_enable_pin_i <= 4'he;
    wr(7'h02, 40'h0107bf);
    tick;
    chk({pll1_up_o, pll1_source_pick_o, pll2_source_pick_o}, 3'b110);
    chk(drv_p_en_o, 5'h0d);
    rd(7'h02, 40'h01a7bf);
    chk(drv_run_o, 5'h0d);
    for (i = 0; i < 4; i = i + 1) begin
      v = {$random(seed)} & 40'h00f700;
      v[7:0] = {4{i[1:0]}};
      wr(7'h04, v);
      tick;
      chk({xtal_trim_o, xtal_cap_o, xtal_gain_o, driver_format_field_o[7:0]},
          {v[15:12], v[10:8], v[7:0]});
      chk(drv_n_en_o, (i == 0) ? 5'h00 : 5'h0d);
      rd(7'h04, v);
    end
    wr(7'h02, 40'h0105b7);
    tick;
    chk({pll2_up_o, drv_p_en_o, drv_run_o}, 11'h000);
    for (i = 0; i < 3; i = i + 1) begin
      v = {$random(seed)};
      m8 = {v[7:4], i[1:0], 2'd2 - i[1:0]};
      wr(7'h05, {32'h0, m8});
      wr(7'h06, {8'h0, v[31:0]});
      wr(7'h07, {4'h0, v[3:0], v[31:0]});
      wr(7'h08, {4'h0, ~v[3:0], ~v[31:0]});
      tick;
      chk({pll2_mode_o, pll1_mode_o, out_div_half_o, out_div_code_o},
          {m8[3:0], m8[7:4], v[31:0]});
      chk({pll1_fb_int_o, pll1_fb_frac_o}, {v[3:0], v[31:0]});
      chk({pll2_fb_int_o, pll2_fb_frac_o}, {~v[3:0], ~v[31:0]});
    end
    rd(7'h7f, 40'h0);
    rd(7'h00, 40'h0);
    wr(7'h02, 40'h0c0000);
    tick;
    chk({cfg_ready_o, driver_format_field_o, pll1_mode_o}, 13'h0000);
    ready;
    rd(7'h04, 40'h0);
    end_sim;
  end
endmodule
